// File: hw/scp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Falling chip select begins a cycle
// R2 - Chip select high on byte boundary stalls
// R3 - Chip select low resumes; after last byte ends
// R4 - Host aborts stall by short partial byte
// R5 - Mid-byte chip select rise resets, flushes byte
// R6 - Streaming accepts bytes until chip select rises
// R7 - First sixteen rising edges form instruction
// R8 - Write bits sampled on rise into shadow
// R9 - Instruction: direction, length, start address
// R10 - Length code: one, two, three, stream
// R11 - Host sends zero upper address bits
// R12 - Update bit copies shadow to active, clears
// R13 - Multibyte steps every address, none skipped
// R14 - Read shifts out N bytes or stream
// R15 - Read bit valid at falling serial clock
// R16 - Configuration bits select separate readback pin
// R17 - Readback select picks shadow or active
// R18 - Host writes mirrored configuration byte
// R19 - LSB-first bits act immediately
// R20 - MSB-first: address decrements per byte
// R21 - LSB-first: address increments per byte
// R22 - Streams stop at top address
// R23 - Soft reset held until next serial clock
// R24 - Data outputs released while chip select high
// R25 - Only sixteen-bit instruction accepted
// R26 - Direction one reads; select one reads active
module scp_serial_port (
	input  wire logic       ref_clk,                 // 40 MHz clock
	input  wire logic       srst,                    // Sync reset
	input  wire logic       clk_en,                  // Freezes state
	input  wire logic       cs_n,                    // Chip select pin
	input  wire logic       sclk,                    // Serial clock pin
	input  wire logic       sdio_in,                 // Data pin in
	output logic            sdio_out,                // Data pin out
	output logic            sdio_oe,                 // Data pin drive
	output logic            serial_readback_pin_out, // Readback out
	output logic            serial_readback_pin_oe,  // Readback drive
	input  wire logic [9:0] act_rd_addr,             // Active read addr
	output logic [7:0]      act_rd_data,             // Active read data
	output logic            soft_reset_busy,         // Soft reset held
	output logic            update_pulse             // Shadow copied
);
	localparam int WBUF = scp_pkg::MAP_AW + 8;

	logic [1:0]        cs_sy_r;
	logic [1:0]        sck_sy_r;
	logic [1:0]        sdi_sy_r;
	logic              cs_d_r;
	logic              sck_d_r;
	scp_pkg::scp_phase_t phase_r;
	logic [2:0]        bit_cnt_r;
	logic              ibyte_r;
	logic              instr_done_r;
	logic [7:0]        sh_r;
	logic [7:0]        sh_nxt;
	logic [7:0]        hi_byte_r;
	logic              rw_r;
	logic              stream_r;
	logic [1:0]        left_r;
	logic [12:0]       addr_r;
	logic              wrapped_r;
	logic [7:0]        out_sh_r;
	logic [7:0]        cfg_r;
	logic              soft_hold_r;
	logic              pend_v_r;
	logic [WBUF-1:0]   pend_d_r;
	logic              buf_in_ready;
	logic              buf_out_valid;
	logic [WBUF-1:0]   buf_out_data;
	logic              wr_en;
	logic [9:0]        wr_addr;
	logic [7:0]        wr_data;
	logic              upd_now;
	logic [7:0]        shadow_m [0:scp_pkg::MAP_WORDS-1];
	logic [7:0]        active_m [0:scp_pkg::MAP_WORDS-1];
	logic              cs_low;
	logic              cs_fall;
	logic              cs_rise;
	logic              sck_rise;
	logic              shifting;
	logic              byte_done;
	logic              lsb;
	logic              uni;
	logic [15:0]       instr;
	logic [12:0]       step_addr;
	logic              stop_now;
	logic              drive;

	// Pin synchronisers: logic reads the second stage and, for chip select and serial clock, its delayed copy
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cs_sy_r  <= 2'h3;
			sck_sy_r <= 2'h0;
			sdi_sy_r <= 2'h0;
			cs_d_r   <= 1'b1;
			sck_d_r  <= 1'b0;
		end else if (clk_en) begin
			cs_sy_r  <= {cs_sy_r[0], cs_n};
			sck_sy_r <= {sck_sy_r[0], sclk};
			sdi_sy_r <= {sdi_sy_r[0], sdio_in};
			cs_d_r   <= cs_sy_r[1];
			sck_d_r  <= sck_sy_r[1];
		end
	end

	assign cs_low   = ~cs_sy_r[1];
	// R1 cycle start edge
	assign cs_fall  = cs_d_r & ~cs_sy_r[1];
	assign cs_rise  = ~cs_d_r & cs_sy_r[1];
	assign sck_rise = sck_sy_r[1] & ~sck_d_r & clk_en;
	assign shifting = (phase_r == scp_pkg::PH_SHIFT) & cs_low;
	assign byte_done = shifting & sck_rise & (bit_cnt_r == scp_pkg::BIT_LAST);

	// R19 order acts at once
	assign lsb = cfg_r[scp_pkg::CFG_LSB_HI] | cfg_r[scp_pkg::CFG_LSB_LO];
	// R16 separate readback pin
	assign uni = cfg_r[scp_pkg::CFG_UNI_HI] | cfg_r[scp_pkg::CFG_UNI_LO];

	// R8 sample on rising edge
	assign sh_nxt = lsb ? {sdi_sy_r[1], sh_r[7:1]} : {sh_r[6:0], sdi_sy_r[1]};

	// R9 fields, first byte is the high half when MSB first
	assign instr = lsb ? {sh_nxt, hi_byte_r} : {hi_byte_r, sh_nxt};

	// R20 R21 address stepping with wrap below zero
	always_comb begin
		if (lsb) begin
			step_addr = addr_r + 13'h1;
		end else if (addr_r == '0) begin
			step_addr = {3'h0, scp_pkg::MAP_LAST};
		end else begin
			step_addr = addr_r - 13'h1;
		end
	end

	// R22 stream ends at top address
	assign stop_now = stream_r & (addr_r[9:0] == scp_pkg::MAP_LAST)
		& (lsb | wrapped_r);

	function automatic logic in_map(input logic [12:0] a);
		in_map = (a[12:10] == 3'h0) && (a[9:0] <= scp_pkg::MAP_LAST);
	endfunction

	// R17 R26 readback source
	function automatic logic [7:0] rd_val(input logic [12:0] a);
		logic [7:0] v;
		v = scp_pkg::REG_RST_VAL;
		if (!in_map(a)) begin
			v = scp_pkg::REG_RST_VAL;
		end else if (a[9:0] == scp_pkg::REG_CFG) begin
			v = cfg_r;
			v[scp_pkg::CFG_SR_HI] = soft_hold_r;
			v[scp_pkg::CFG_SR_LO] = soft_hold_r;
		end else if (active_m[scp_pkg::REG_RBSEL][scp_pkg::RBSEL_BIT]) begin
			v = active_m[a[9:0]];
		end else begin
			v = shadow_m[a[9:0]];
		end
		rd_val = v;
	endfunction

	// Phase and bit counting
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_r      <= scp_pkg::PH_IDLE;
			bit_cnt_r    <= scp_pkg::BIT_FIRST;
			ibyte_r      <= 1'b0;
			instr_done_r <= 1'b0;
		end else if (clk_en) begin
			if (cs_rise) begin
				case (phase_r)
					scp_pkg::PH_SHIFT: begin
						// R5 R4 mid-byte rise resets the port
						if (bit_cnt_r != scp_pkg::BIT_FIRST) begin
							phase_r <= scp_pkg::PH_IDLE;
						// R2 stall on byte boundary
						end else if (!instr_done_r) begin
							phase_r <= scp_pkg::PH_STALL;
						// R6 stream ended by rise
						end else if (stream_r) begin
							phase_r <= scp_pkg::PH_IDLE;
						end else begin
							phase_r <= scp_pkg::PH_STALL;
						end
					end
					scp_pkg::PH_STALL: begin
						phase_r <= scp_pkg::PH_STALL;
					end
					default: begin
						phase_r <= scp_pkg::PH_IDLE;
					end
				endcase
			end else if (cs_fall) begin
				case (phase_r)
					// R3 resume after stall
					scp_pkg::PH_STALL: begin
						phase_r <= scp_pkg::PH_SHIFT;
					end
					// R1 new cycle
					default: begin
						phase_r      <= scp_pkg::PH_SHIFT;
						bit_cnt_r    <= scp_pkg::BIT_FIRST;
						ibyte_r      <= 1'b0;
						instr_done_r <= 1'b0;
					end
				endcase
			end else if (shifting && sck_rise) begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (byte_done && !instr_done_r) begin
					// R7 R25 two instruction bytes always
					ibyte_r      <= 1'b1;
					instr_done_r <= ibyte_r;
				end else if (byte_done) begin
					// R3 R10 last counted byte closes the cycle
					if ((!stream_r && left_r == 2'h0) || stop_now) begin
						phase_r <= scp_pkg::PH_DONE;
					end
				end
			end
		end
	end

	// Instruction fields, address and read shifter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sh_r      <= 8'h00;
			hi_byte_r <= 8'h00;
			rw_r      <= 1'b0;
			stream_r  <= 1'b0;
			left_r    <= 2'h0;
			addr_r    <= 13'h0;
			wrapped_r <= 1'b0;
			out_sh_r  <= 8'h00;
		end else if (clk_en && shifting && sck_rise) begin
			sh_r <= sh_nxt;
			if (byte_done && !instr_done_r && !ibyte_r) begin
				hi_byte_r <= sh_nxt;
			end else if (byte_done && !instr_done_r) begin
				// R26 direction one means read
				rw_r      <= instr[scp_pkg::INS_RW];
				// R10 length code
				left_r    <= instr[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO];
				stream_r  <= (instr[scp_pkg::INS_LEN_HI:scp_pkg::INS_LEN_LO]
					== scp_pkg::LEN_STREAM);
				addr_r    <= instr[scp_pkg::INS_ADR_HI:0];
				wrapped_r <= 1'b0;
				out_sh_r  <= rd_val(instr[scp_pkg::INS_ADR_HI:0]);
			end else if (byte_done) begin
				// R13 every address visited in turn
				addr_r   <= step_addr;
				left_r   <= left_r - 2'h1;
				out_sh_r <= rd_val(step_addr);
				if (!lsb && addr_r == 13'h0) begin
					wrapped_r <= 1'b1;
				end
			end else if (lsb) begin
				out_sh_r <= {1'b0, out_sh_r[7:1]};
			end else begin
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	// Finished write bytes wait here until the buffer has room
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pend_v_r <= 1'b0;
			pend_d_r <= '0;
		end else if (clk_en) begin
			// R8 completed write byte heads for the shadow
			if (byte_done && instr_done_r && !rw_r && in_map(addr_r)) begin
				pend_v_r <= 1'b1;
				pend_d_r <= {addr_r[9:0], sh_nxt};
			end else if (buf_in_ready) begin
				pend_v_r <= 1'b0;
			end
		end
	end

	scp_pair_buf #(
		.W     (WBUF),
		.DEPTH (2)
	) u_buf (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.clk_en    (clk_en),
		.in_valid  (pend_v_r),
		.in_ready  (buf_in_ready),
		.in_data   (pend_d_r),
		.out_valid (buf_out_valid),
		.out_ready (~soft_hold_r),
		.out_data  (buf_out_data)
	);

	assign wr_en   = buf_out_valid & ~soft_hold_r & clk_en;
	assign wr_addr = buf_out_data[WBUF-1:8];
	assign wr_data = buf_out_data[7:0];
	// R12 update trigger
	assign upd_now = wr_en & (wr_addr == scp_pkg::REG_UPD)
		& wr_data[scp_pkg::UPD_BIT];

	// Configuration register takes effect without an update
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg_r       <= scp_pkg::REG_RST_VAL;
			soft_hold_r <= 1'b0;
			update_pulse <= 1'b0;
		end else if (clk_en) begin
			update_pulse <= upd_now;
			if (wr_en && wr_addr == scp_pkg::REG_CFG) begin
				cfg_r <= wr_data;
				cfg_r[scp_pkg::CFG_SR_HI] <= 1'b0;
				cfg_r[scp_pkg::CFG_SR_LO] <= 1'b0;
				// R23 soft reset request
				if (wr_data[scp_pkg::CFG_SR_HI] && wr_data[scp_pkg::CFG_SR_LO]) begin
					soft_hold_r <= 1'b1;
				end
			// R23 released by the next serial clock
			end else if (soft_hold_r && sck_rise) begin
				soft_hold_r <= 1'b0;
			end
		end
	end
	assign soft_reset_busy = soft_hold_r;

	// Shadow and active copies of every map entry
	for (genvar g = 0; g < scp_pkg::MAP_WORDS; g++) begin : g_map
		localparam logic [9:0] IDX = 10'(g);
		always_ff @(posedge ref_clk) begin
			if (srst || soft_hold_r) begin
				shadow_m[g] <= scp_pkg::REG_RST_VAL;
			end else if (wr_en && wr_addr == IDX) begin
				shadow_m[g] <= (IDX == scp_pkg::REG_UPD)
					? {wr_data[7:1], 1'b0} : wr_data;
			end
		end
		always_ff @(posedge ref_clk) begin
			if (srst || soft_hold_r) begin
				active_m[g] <= scp_pkg::REG_RST_VAL;
			// R12 all entries copied at once
			end else if (upd_now) begin
				active_m[g] <= shadow_m[g];
			end
		end
	end

	// R14 drive while a read data phase runs
	assign drive = shifting & instr_done_r & rw_r;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sdio_out                <= 1'b0;
			sdio_oe                 <= 1'b0;
			serial_readback_pin_out <= 1'b0;
			serial_readback_pin_oe  <= 1'b0;
			act_rd_data             <= 8'h00;
		end else if (clk_en) begin
			// R15 bit updated after rise, stable at the fall
			sdio_out                <= lsb ? out_sh_r[0] : out_sh_r[7];
			serial_readback_pin_out <= lsb ? out_sh_r[0] : out_sh_r[7];
			// R24 R16 released while chip select high
			sdio_oe                 <= drive & ~uni;
			serial_readback_pin_oe  <= drive & uni;
			act_rd_data <= (act_rd_addr <= scp_pkg::MAP_LAST)
				? active_m[act_rd_addr] : scp_pkg::REG_RST_VAL;
		end
	end
endmodule
`default_nettype wire

// File: common/scp_pkg.sv
`default_nettype none
package scp_pkg;
	localparam int         MAP_AW      = 10;
	localparam int         INSTR_AW    = 13;
	localparam int         MAP_WORDS   = 563;
	localparam logic [9:0] MAP_LAST    = 10'h232;
	localparam logic [9:0] REG_CFG     = 10'h000;
	localparam logic [9:0] REG_RBSEL   = 10'h004;
	localparam logic [9:0] REG_UPD     = 10'h232;
	localparam logic [7:0] REG_RST_VAL = 8'h00;
	// Configuration bit pairs, mirrored about the byte centre
	localparam int         CFG_UNI_HI  = 7;
	localparam int         CFG_UNI_LO  = 0;
	localparam int         CFG_LSB_HI  = 6;
	localparam int         CFG_LSB_LO  = 1;
	localparam int         CFG_SR_HI   = 5;
	localparam int         CFG_SR_LO   = 2;
	localparam int         RBSEL_BIT   = 0;
	localparam int         UPD_BIT     = 0;
	// Instruction word layout
	localparam int         INS_RW      = 15;
	localparam int         INS_LEN_HI  = 14;
	localparam int         INS_LEN_LO  = 13;
	localparam int         INS_ADR_HI  = 12;
	localparam logic [1:0] LEN_STREAM  = 2'h3;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [2:0] BIT_FIRST   = 3'h0;
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SHIFT = 2'b01,
		PH_STALL = 2'b10,
		PH_DONE  = 2'b11
	} scp_phase_t;
endpackage
`default_nettype wire

// File: hw/scp_pair_buf.sv
`timescale 1ns/1ps
`default_nettype none
module scp_pair_buf #(
	parameter int W     = 18,
	parameter int DEPTH = 2
) (
	input  wire logic         ref_clk,   // System clock
	input  wire logic         srst,      // Synchronous reset
	input  wire logic         clk_en,    // Freezes state when low
	input  wire logic         in_valid,  // Word offered
	output logic              in_ready,  // Room for a word
	input  wire logic [W-1:0] in_data,   // Offered word
	output logic              out_valid, // Word available
	input  wire logic         out_ready, // Drain side takes word
	output logic [W-1:0]      out_data   // Oldest word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
		nxt = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (clk_en && push) begin
			mem[wp_r] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (push) begin
				wp_r <= nxt(wp_r);
			end
			if (pop) begin
				rp_r <= nxt(rp_r);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + (PW+1)'(1);
			end else if (pop && !push) begin
				cnt_r <= cnt_r - (PW+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/scp_serial_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port_asserts (
	input wire logic       ref_clk,                // Clock
	input wire logic       srst,                   // Reset
	input wire logic       cs_n,                   // Chip select
	input wire logic       sclk,                   // Serial clock
	input wire logic       sdio_out,               // Data out
	input wire logic       sdio_oe,                // Data drive
	input wire logic       serial_readback_pin_oe, // Readback drive
	input wire logic [9:0] act_rd_addr,            // Lookup address
	input wire logic [7:0] act_rd_data,            // Lookup data
	input wire logic       soft_reset_busy,        // Soft reset held
	input wire logic       update_pulse            // Update done
);
	logic [3:0] lo_cnt;
	// Cycles the serial clock has stayed low
	always_ff @(posedge ref_clk) begin
		if (srst || sclk) begin
			lo_cnt <= 4'h0;
		end else if (lo_cnt != 4'hF) begin
			lo_cnt <= lo_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	a_idle_release: assert property (
		cs_n [*6] |-> !sdio_oe && !serial_readback_pin_oe)
		else $error("data pin driven with chip select high");
	a_one_pin: assert property (
		!(sdio_oe && serial_readback_pin_oe))
		else $error("both data pins driven");
	a_update_pulse: assert property (
		update_pulse |=> !update_pulse)
		else $error("update pulse longer than one cycle");
	a_update_cause: assert property (
		update_pulse |-> !$past(cs_n, 12))
		else $error("update without a transfer");
	a_drive_start: assert property (
		$rose(sdio_oe || serial_readback_pin_oe) |-> !cs_n && !$past(cs_n, 3))
		else $error("read drive outside a cycle");
	a_bit_steady: assert property (
		sdio_oe && $past(sdio_oe) && lo_cnt >= 4'h5 |-> $stable(sdio_out))
		else $error("read bit moved without a serial clock rise");
	a_soft_release: assert property (
		$fell(soft_reset_busy) |-> lo_cnt < 4'h4)
		else $error("soft reset released without a serial clock rise");
	a_map_end: assert property (
		$past(act_rd_addr) > 10'h232 |-> act_rd_data == 8'h00)
		else $error("lookup beyond the map not zero");
endmodule
bind scp_serial_port scp_serial_port_asserts u_chk (
	.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
	.sdio_out(sdio_out), .sdio_oe(sdio_oe),
	.serial_readback_pin_oe(serial_readback_pin_oe),
	.act_rd_addr(act_rd_addr), .act_rd_data(act_rd_data),
	.soft_reset_busy(soft_reset_busy), .update_pulse(update_pulse)
);
`default_nettype wire

// File: sim/scp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
	input  wire logic       ref_clk, // System clock
	input  wire logic       lsb,     // Low bit first
	input  wire logic       uni,     // Read on readback pin
	input  wire logic       sdio,    // Shared data wire
	input  wire logic       rbp,     // Readback wire
	output logic            cs_n,    // Chip select
	output logic            sclk,    // Serial clock
	output logic            mosi_d,  // Host data drive
	output logic [7:0]      rx,      // Byte read back
	output logic            rx_stb   // Read byte ready
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi_d = 1'b0;
		rx = 8'h00;
		rx_stb = 1'b0;
	end
	// cycle opens and closes on chip select
	task automatic sel(input logic on);
		repeat (4) @(posedge ref_clk);
		cs_n <= ~on;
		repeat (4) @(posedge ref_clk);
	endtask
	// chip select parked high on a byte boundary
	task automatic pause();
		sel(1'b0);
		sel(1'b1);
	endtask
	// bit set up before each rise, read bit taken first
	task automatic xb(input logic [7:0] d, input logic chk, input int nb);
		logic [7:0] q;
		int         i;
		q = 8'h00;
		for (int k = 0; k < nb; k++) begin
			i = lsb ? k : 7 - k;
			mosi_d <= d[i];
			repeat (3) @(posedge ref_clk);
			#1 q[i] = uni ? rbp : sdio;
			@(posedge ref_clk);
			sclk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		if (chk) begin
			rx <= q;
			rx_stb <= 1'b1;
			@(posedge ref_clk);
			rx_stb <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// File: sim/scp_serial_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port_test;
	logic        ref_clk, srst, lsb, uni, act_stb, en, lv_stb;
	logic        cs_n, sclk, mosi_d, rx_stb, sdio_out, sdio_oe;
	logic        rb_out, rb_oe, srb, upd;
	logic [9:0]  act_rd_addr;
	logic [7:0]  rx, act_rd_data, got, exp_v, lv, upd_cnt;
	logic [7:0]  txd [8];
	logic [7:0]  v [3];
	logic [7:0]  exp_q [$];
	logic [15:0] rnd;
	int          miscompares, check_count;
	wire         sdio_w = sdio_oe ? sdio_out : mosi_d;
	wire         rbp = rb_oe ? rb_out : ~sclk;

	scp_serial_port u_dut (
		.ref_clk(ref_clk), .srst(srst), .clk_en(en),
		.cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_w),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.serial_readback_pin_out(rb_out), .serial_readback_pin_oe(rb_oe),
		.act_rd_addr(act_rd_addr), .act_rd_data(act_rd_data),
		.soft_reset_busy(srb), .update_pulse(upd)
	);
	scp_host_model u_host (
		.ref_clk(ref_clk), .lsb(lsb), .uni(uni), .sdio(sdio_w),
		.rbp(rbp), .cs_n(cs_n), .sclk(sclk), .mosi_d(mosi_d),
		.rx(rx), .rx_stb(rx_stb)
	);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Instruction then n data bytes, optionally stalled between bytes
	task automatic xfer(input logic [15:0] ins, input int n, input logic st);
		logic [15:0] w;
		u_host.sel(1'b1);
		// Order read after any pending bit-order change has settled
		w = lsb ? {ins[7:0], ins[15:8]} : ins;
		u_host.xb(w[15:8], 1'b0, 8);
		if (st)
			u_host.pause();
		u_host.xb(w[7:0], 1'b0, 8);
		for (int k = 0; k < n; k++) begin
			if (st && k > 0)
				u_host.pause();
			u_host.xb(txd[k], ins[15], 8);
		end
		u_host.sel(1'b0);
	endtask

	task automatic wr1(input logic [9:0] a, input logic [7:0] d);
		txd[0] = d;
		xfer({6'h00, a}, 1, 1'b0);
	endtask

	task automatic rd1(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		xfer({6'h20, a}, 1, 1'b0);
	endtask

	task automatic act(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		act_rd_addr <= a;
		@(posedge ref_clk);
		act_stb <= 1'b1;
		@(posedge ref_clk);
		act_stb <= 1'b0;
	endtask

	// Level seen now, compared against a noted value
	task automatic lvl(input logic [7:0] g, input logic [7:0] e);
		exp_q.push_back(e);
		lv <= g;
		lv_stb <= 1'b1;
		@(posedge ref_clk);
		lv_stb <= 1'b0;
	endtask

	always @(posedge ref_clk) begin
		if (upd === 1'b1) begin
			upd_cnt <= upd_cnt + 8'h01;
		end
	end

	always @(posedge ref_clk) begin
		if (rx_stb || act_stb || lv_stb) begin
			exp_v = exp_q.pop_front();
			got = act_stb ? act_rd_data : (lv_stb ? lv : rx);
			check_count++;
			if (got !== exp_v) begin
				miscompares++;
				$display("mismatch %0t got %h exp %h", $time, got, exp_v);
			end
		end
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		srst = 1'b1;
		lsb = 1'b0;
		uni = 1'b0;
		act_stb = 1'b0;
		en = 1'b1;
		lv_stb = 1'b0;
		lv = 8'h00;
		upd_cnt = 8'h00;
		act_rd_addr = 10'h000;
		rnd = 16'h95F2;
		miscompares = 0;
		check_count = 0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rd1(10'h000, 8'h00);
		rd1(10'h004, 8'h00);
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			txd[k] = rnd[7:0];
			v[k] = rnd[7:0];
		end
		xfer({6'h10, 10'h012}, 3, 1'b1);
		act(10'h011, 8'h00);
		// Freeze while idle; state must survive
		en <= 1'b0;
		repeat (6) @(posedge ref_clk);
		en <= 1'b1;
		for (int k = 0; k < 3; k++)
			exp_q.push_back(v[k]);
		xfer({6'h30, 10'h012}, 3, 1'b1);
		// Stalled write abandoned by a short partial byte
		u_host.sel(1'b1);
		u_host.xb(8'h00, 1'b0, 8);
		u_host.xb(8'h11, 1'b0, 8);
		u_host.pause();
		u_host.xb(8'hFF, 1'b0, 3);
		u_host.sel(1'b0);
		rd1(10'h011, v[1]);
		wr1(10'h232, 8'h01);
		act(10'h010, v[2]);
		act(10'h3FF, 8'h00);
		rd1(10'h232, 8'h00);
		// Decrementing stream wraps below zero, then stops
		txd[0] = v[0];
		txd[1] = 8'h00;
		txd[2] = 8'h00;
		txd[3] = 8'hFF;
		xfer({6'h18, 10'h001}, 4, 1'b0);
		exp_q.push_back(v[0]);
		exp_q.push_back(8'h00);
		exp_q.push_back(8'h00);
		xfer({6'h38, 10'h001}, 3, 1'b0);
		wr1(10'h000, 8'hC3);
		lsb <= 1'b1;
		uni <= 1'b1;
		rnd = lfsr(rnd);
		txd[0] = rnd[7:0];
		txd[1] = 8'h00;
		txd[2] = 8'h01;
		txd[3] = 8'hFF;
		xfer({6'h18, 10'h230}, 4, 1'b0);
		act(10'h230, txd[0]);
		exp_q.push_back(txd[0]);
		exp_q.push_back(8'h00);
		xfer({6'h38, 10'h230}, 2, 1'b0);
		wr1(10'h004, 8'h01);
		wr1(10'h232, 8'h01);
		wr1(10'h010, ~v[2]);
		rd1(10'h010, v[2]);
		wr1(10'h000, 8'hE7);
		lvl({7'h00, srb}, 8'h01);
		rd1(10'h010, 8'h00);
		lvl({7'h00, srb}, 8'h00);
		rd1(10'h000, 8'hC3);
		lvl(upd_cnt, 8'h03);
		repeat (20) @(posedge ref_clk);
		end_of_test();
	end
endmodule
`default_nettype wire
